// ### core/bcrl_top.sv
// Purpose: boot clock selection and reboot loader sequencer
// Assumes: register port with read data one cycle later
// Notes:   words come from a staging memory filled over the port
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`include "bcrl_defs.svh"
module bcrl_top #(
  parameter int AW = 6
) (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire bcrl_pkg::bcrl_mode_t  boot_mode_i,
  input  wire logic [3:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [31:0]           rdata_o,
  output bcrl_pkg::bcrl_clk_t        clk_ctrl_o,
  output bcrl_pkg::bcrl_wr_t         mem_wr_o,
  output logic      [15:0]           host_status_o,
  output logic      [15:0]           serial_status_o,
  output logic      [15:0]           index_o
);
  import bcrl_pkg::*;

  typedef enum logic [1:0] {BCRL_IDLE, BCRL_READ, BCRL_WRITE, BCRL_END} bcrl_state_t;

  bcrl_state_t state, next_state;
  bcrl_args_t  args, next_args;
  bcrl_mode_t  entry, next_entry;
  bcrl_wr_t    wr, next_wr;
  bcrl_clk_t   clk_ctrl;
  logic [15:0] count, next_count;
  logic [7:0]  dp_sel, next_dp_sel;
  logic [15:0] hst, next_hst;
  logic [15:0] sst, next_sst;
  logic [15:0] idx, next_idx;
  logic [1:0]  stack, next_stack;
  logic [2:0]  status, next_status;
  logic        boot_pend, next_boot_pend;
  logic        boot_start;
  logic [AW-1:0] waddr, next_waddr;
  logic [31:0] mem_rdata;
  logic [31:0] rdata, next_rdata;

  function automatic logic [15:0] word_limit(input bcrl_mode_t m);
    if (m == BCRL_BOOT_HOST || m == BCRL_BOOT_SERIAL || m == BCRL_BOOT_EXT) begin
      return `BCRL_MAX_STR_WORDS;
    end
    return `BCRL_MAX_MEM_WORDS;
  endfunction

  function automatic logic entry_ok(input logic [2:0] e);
    return (e >= `BCRL_ENTRY_MIN) && (e <= `BCRL_ENTRY_MAX);
  endfunction

  assign boot_start = boot_pend;

  bcrl_clk_ctrl u_clk (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .boot_start_i (boot_start),
    .mode_i       (boot_mode_i),
    .clk_ctrl_o   (clk_ctrl)
  );

  bcrl_stage_mem #(.AW(AW)) u_mem (
    .clk_i   (clk_i),
    .we_i    (wr_i && addr_i == `BCRL_OFF_DATA),
    .waddr_i (waddr),
    .wdata_i (wdata_i),
    .raddr_i (count[AW-1:0]),
    .rdata_o (mem_rdata)
  );

  always_comb begin
    next_state     = state;
    next_args      = args;
    next_entry     = entry;
    next_wr        = wr;
    next_wr.valid  = 1'b0;
    next_count     = count;
    next_dp_sel    = dp_sel;
    next_hst       = hst;
    next_sst       = sst;
    next_idx       = idx;
    next_stack     = stack;
    next_status    = status;
    next_boot_pend = 1'b0;
    next_waddr     = waddr;
    next_rdata     = '0;
    if (wr_i) begin
      unique case (addr_i)
        `BCRL_OFF_STEPS: next_args.steps = wdata_i[15:0];
        `BCRL_OFF_SRC:   next_args.src   = wdata_i[15:0];
        `BCRL_OFF_DPAGE: next_args.dpage = wdata_i[7:0];
        `BCRL_OFF_ENTRY: next_entry      = bcrl_mode_t'(wdata_i[2:0]);
        `BCRL_OFF_DATA:  next_waddr      = waddr + 1'b1;
        `BCRL_OFF_CTRL: begin
          if (wdata_i[`BCRL_CTRL_START] && state == BCRL_IDLE) begin
            if (!entry_ok(entry) || args.steps > word_limit(entry)) begin
              next_status[`BCRL_ST_ERR] = 1'b1;
              // refused start still rewinds staging so the next fill lands at word 0
              next_waddr                = '0;
            end else begin
              next_state                 = BCRL_READ;
              next_count                 = '0;
              next_stack                 = 2'h2;
              next_status                = 3'b001;
              next_waddr                 = '0;
              next_wr.to_data            = args.dpage <= `BCRL_PAGE_DATA_MAX;
              next_wr.page               = args.dpage;
              next_dp_sel                = args.dpage;
              unique case (entry)
                BCRL_BOOT_EXT:    next_idx = args.src;
                BCRL_BOOT_HOST:   next_hst = args.src;
                BCRL_BOOT_SERIAL: next_sst = args.src;
                default:          next_dp_sel = args.src[7:0];
              endcase
            end
          end
        end
        default: begin
        end
      endcase
    end
    unique case (state)
      BCRL_IDLE: begin
      end
      BCRL_READ: begin
        if (count == args.steps) begin
          next_state = BCRL_END;
        end else begin
          next_state = BCRL_WRITE;
        end
      end
      BCRL_WRITE: begin
        next_wr.valid = 1'b1;
        next_wr.addr  = count;
        next_wr.data  = mem_rdata;
        next_count    = count + 1'b1;
        next_state    = BCRL_READ;
      end
      BCRL_END: begin
        next_dp_sel = `BCRL_PAGE_RESET;
        next_stack  = 2'h0;
        next_status = 3'b010;
        next_state  = BCRL_IDLE;
      end
    endcase
    if (rd_i) begin
      unique case (addr_i)
        `BCRL_OFF_STEPS:  next_rdata = {16'h0, args.steps};
        `BCRL_OFF_SRC:    next_rdata = {16'h0, args.src};
        `BCRL_OFF_DPAGE:  next_rdata = {24'h0, args.dpage};
        `BCRL_OFF_ENTRY:  next_rdata = {29'h0, entry};
        `BCRL_OFF_STATUS: next_rdata = {29'h0, status};
        `BCRL_OFF_XFER:   next_rdata = {16'h0, count};
        `BCRL_OFF_CLK:    next_rdata = {24'h0, clk_ctrl};
        `BCRL_OFF_DPSEL:  next_rdata = {24'h0, dp_sel};
        `BCRL_OFF_STACK:  next_rdata = {30'h0, stack};
        default:          next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state     <= BCRL_IDLE;
      args      <= '0;
      entry     <= BCRL_BOOT_NONE;
      wr        <= '0;
      count     <= '0;
      dp_sel    <= `BCRL_PAGE_INIT;
      hst       <= `BCRL_HST_RESET;
      sst       <= `BCRL_SST_FIXED;
      idx       <= '0;
      stack     <= '0;
      status    <= '0;
      boot_pend <= 1'b1;
      waddr     <= '0;
      rdata     <= '0;
    end else begin
      state     <= next_state;
      args      <= next_args;
      entry     <= next_entry;
      wr        <= next_wr;
      count     <= next_count;
      dp_sel    <= next_dp_sel;
      hst       <= next_hst;
      sst       <= next_sst;
      idx       <= next_idx;
      stack     <= next_stack;
      status    <= next_status;
      boot_pend <= next_boot_pend;
      waddr     <= next_waddr;
      rdata     <= next_rdata;
    end
  end

  assign rdata_o         = rdata;
  assign clk_ctrl_o      = clk_ctrl;
  assign mem_wr_o        = wr;
  assign host_status_o   = hst;
  assign serial_status_o = sst;
  assign index_o         = idx;
endmodule // bcrl_top

// ### shared/bcrl_defs.svh
// Purpose: constants of the boot clock and reboot loader
// Assumes: 100 MHz system clock
// Notes:   offsets, field positions, reset values and counts
`ifndef BCRL_DEFS_SVH
`define BCRL_DEFS_SVH

// register port offsets
`define BCRL_OFF_CTRL      4'h0
`define BCRL_OFF_STEPS     4'h1
`define BCRL_OFF_SRC       4'h2
`define BCRL_OFF_DPAGE     4'h3
`define BCRL_OFF_ENTRY     4'h4
`define BCRL_OFF_STATUS    4'h5
`define BCRL_OFF_XFER      4'h6
`define BCRL_OFF_CLK       4'h7
`define BCRL_OFF_DPSEL     4'h8
`define BCRL_OFF_STACK     4'h9
`define BCRL_OFF_DATA      4'ha

// control bits
`define BCRL_CTRL_START    0
`define BCRL_CTRL_BOOTDONE 1

// entry codes
`define BCRL_ENTRY_MIN     3'h1
`define BCRL_ENTRY_MAX     3'h6

// pages
`define BCRL_PAGE_INIT     8'h80
`define BCRL_PAGE_DATA_MAX 8'h3f
`define BCRL_PAGE_RESET    8'h00
`define BCRL_IMEM_OFFSET   16'h8000

// source argument constants
`define BCRL_SST_FIXED     16'h0ec0
`define BCRL_HST_WAIT_BIT  10
`define BCRL_HST_RESET     16'h0401

// word limits
`define BCRL_MAX_MEM_WORDS 16'h3fff
`define BCRL_MAX_STR_WORDS 16'h7d00

// divider ratio field, 1/1
`define BCRL_DIV_ONE       4'h1

// status bits
`define BCRL_ST_BUSY       0
`define BCRL_ST_DONE       1
`define BCRL_ST_ERR        2

`endif

// ### shared/bcrl_pkg.sv
// Purpose: types of the boot clock and reboot loader
// Assumes: used with bcrl_defs.svh
// Notes:   carriers for clock control and transfer words
package bcrl_pkg;

  typedef enum logic [2:0] {
    BCRL_BOOT_NONE   = 3'h0,
    BCRL_BOOT_X      = 3'h1,
    BCRL_BOOT_Y      = 3'h2,
    BCRL_BOOT_XY     = 3'h3,
    BCRL_BOOT_EXT    = 3'h4,
    BCRL_BOOT_HOST   = 3'h5,
    BCRL_BOOT_SERIAL = 3'h6
  } bcrl_mode_t;

  typedef struct packed {
    logic       pll_run;
    logic       pll_sel;
    logic       div_run;
    logic       div_sel;
    logic [3:0] div_ratio;
  } bcrl_clk_t;

  typedef struct packed {
    logic        valid;
    logic        to_data;
    logic [7:0]  page;
    logic [15:0] addr;
    logic [31:0] data;
  } bcrl_wr_t;

  typedef struct packed {
    logic [15:0] steps;
    logic [15:0] src;
    logic [7:0]  dpage;
  } bcrl_args_t;

endpackage

// ### core/bcrl_clk_ctrl.sv
// Purpose: selects boot clock source per boot mode
// Assumes: synchronous reset, boot mode sampled at release
// Notes:   reset forces external clock
`timescale 1ns/1ns
`include "bcrl_defs.svh"
module bcrl_clk_ctrl (
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic               boot_start_i,
  input  wire bcrl_pkg::bcrl_mode_t mode_i,
  output bcrl_pkg::bcrl_clk_t     clk_ctrl_o
);
  import bcrl_pkg::*;

  bcrl_clk_t clk_q;
  bcrl_clk_t next_clk_q;

  always_comb begin
    next_clk_q = clk_q;
    if (boot_start_i) begin
      next_clk_q.div_run   = 1'b1;
      next_clk_q.div_sel   = 1'b0;
      next_clk_q.div_ratio = `BCRL_DIV_ONE;
      unique case (mode_i)
        BCRL_BOOT_NONE, BCRL_BOOT_EXT: begin
          next_clk_q.pll_run = 1'b0;
          next_clk_q.pll_sel = 1'b0;
        end
        BCRL_BOOT_X, BCRL_BOOT_Y, BCRL_BOOT_XY, BCRL_BOOT_HOST, BCRL_BOOT_SERIAL: begin
          next_clk_q.pll_run = 1'b1;
          next_clk_q.pll_sel = 1'b1;
        end
        default: begin
          next_clk_q.pll_run = 1'b0;
          next_clk_q.pll_sel = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clk_q <= '0;
    end else begin
      clk_q <= next_clk_q;
    end
  end

  assign clk_ctrl_o = clk_q;
endmodule // bcrl_clk_ctrl

// ### core/bcrl_stage_mem.sv
// Purpose: staging memory of 32-bit words to be loaded
// Assumes: one write and one read port, registered read
// Notes:   software fills it before a reboot
`timescale 1ns/1ns
module bcrl_stage_mem #(
  parameter int AW = 6
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [31:0]   wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [31:0]   rdata_o
);
  logic [31:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // bcrl_stage_mem

// ### verif/bcrl_top_monitor.sv
// Purpose: port checker of the boot clock and reboot loader
// Assumes: mode strap held steady between resets
// Notes:   bound from the bench top
`timescale 1ns/1ns
`include "bcrl_defs.svh"
module bcrl_monitor (
  input wire logic                 clk_i,
  input wire logic                 srst_i,
  input wire bcrl_pkg::bcrl_mode_t boot_mode_i,
  input wire bcrl_pkg::bcrl_clk_t  clk_ctrl_o,
  input wire bcrl_pkg::bcrl_wr_t   mem_wr_o,
  input wire logic [15:0]          serial_status_o
);
  import bcrl_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_rel;
    $fell(srst_i);
  endsequence
  sequence s_two;
    mem_wr_o.valid ##2 mem_wr_o.valid;
  endsequence
  property p_rst_clk;
    s_rel |-> clk_ctrl_o == '0;
  endproperty
  property p_noboot;
    s_rel ##0 (boot_mode_i inside {BCRL_BOOT_NONE, BCRL_BOOT_EXT})
      |-> ##3 !clk_ctrl_o.pll_run && !clk_ctrl_o.pll_sel;
  endproperty
  property p_pllboot;
    s_rel ##0 !(boot_mode_i inside {BCRL_BOOT_NONE, BCRL_BOOT_EXT})
      |-> ##3 clk_ctrl_o.pll_run && clk_ctrl_o.pll_sel;
  endproperty
  property p_div;
    s_rel |-> ##3 clk_ctrl_o.div_run && !clk_ctrl_o.div_sel && clk_ctrl_o.div_ratio == `BCRL_DIV_ONE;
  endproperty
  property p_data_pg;
    mem_wr_o.valid |-> mem_wr_o.to_data == (mem_wr_o.page <= `BCRL_PAGE_DATA_MAX);
  endproperty
  property p_pulse;
    mem_wr_o.valid |=> !mem_wr_o.valid;
  endproperty
  property p_seq;
    s_two |-> mem_wr_o.addr == $past(mem_wr_o.addr, 2) + 16'h1 && mem_wr_o.page == $past(mem_wr_o.page, 2);
  endproperty
  property p_sst;
    s_rel |-> serial_status_o == `BCRL_SST_FIXED;
  endproperty
  a_rst_clk: assert property (p_rst_clk) else $error("clock not external after reset");
  a_noboot: assert property (p_noboot) else $error("pll active in external clock boot");
  a_pllboot: assert property (p_pllboot) else $error("pll not selected for boot");
  a_div: assert property (p_div) else $error("divider start wrong");
  a_data_pg: assert property (p_data_pg) else $error("memory target wrong for page");
  a_pulse: assert property (p_pulse) else $error("word pulse too long");
  a_seq: assert property (p_seq) else $error("word order or page broken");
  a_sst: assert property (p_sst) else $error("serial status not fixed value");
endmodule // bcrl_monitor

// ### verif/bcrl_app_model.sv
// Purpose: application program calling the reboot service
// Assumes: register port, read data one cycle later
// Notes:   tasks are called from the bench
`timescale 1ns/1ns
`include "bcrl_defs.svh"
module bcrl_app_model (
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  output logic      [3:0]  addr_o,
  output logic      [31:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o
);
  logic [31:0] words [64];
  initial begin
    addr_o = 4'h0;
    wdata_o = 32'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
  function automatic logic [15:0] src_for(input logic [2:0] e, input logic [15:0] raw);
    if (e == 3'h5) return raw | (16'h1 << `BCRL_HST_WAIT_BIT);
    if (e == 3'h6) return `BCRL_SST_FIXED;
    return raw;
  endfunction
  // caller must start the pll itself after a boot that left it stopped
  function automatic logic must_start_pll(input logic [2:0] m);
    return (m == 3'h0) || (m == 3'h4);
  endfunction
  // caller offsets destination by 0x8000 when the page is 0x80
  function automatic logic [15:0] dest_of(input logic [7:0] p, input logic [15:0] a);
    return (p == `BCRL_PAGE_INIT) ? (a + `BCRL_IMEM_OFFSET) : a;
  endfunction
  task automatic reboot(input logic [2:0] e, input logic [15:0] n, input logic [15:0] s, input logic [7:0] p);
    wr(`BCRL_OFF_STEPS, {16'h0, n});
    wr(`BCRL_OFF_SRC, {16'h0, s});
    wr(`BCRL_OFF_DPAGE, {24'h0, p});
    wr(`BCRL_OFF_ENTRY, {29'h0, e});
    for (int i = 0; i < 64 && i < n; i++) wr(`BCRL_OFF_DATA, words[i]);
    wr(`BCRL_OFF_CTRL, 32'h1);
  endtask
endmodule // bcrl_app_model

// ### verif/bcrl_top_tb_top.sv
// Purpose: self-checking bench of the boot clock and reboot loader
// Assumes: seed fixed, staging memory of 64 words
// Notes:   boot clock per mode, reboots per entry, refusals
`timescale 1ns/1ns
`include "bcrl_defs.svh"
module boot_clock_and_reboot_loader_tb_top;
  import bcrl_pkg::*;
  logic       clk_i;
  logic       srst_i;
  bcrl_mode_t boot_mode_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [31:0] rdata_o;
  bcrl_clk_t  clk_ctrl_o;
  bcrl_wr_t   mem_wr_o;
  logic [15:0] host_status_o;
  logic [15:0] serial_status_o;
  logic [15:0] index_o;
  bcrl_wr_t   got [$];
  int         num_errors = 0;
  int         check_count = 0;
  bcrl_top #(.AW(6)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .boot_mode_i(boot_mode_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clk_ctrl_o(clk_ctrl_o),
    .mem_wr_o(mem_wr_o), .host_status_o(host_status_o), .serial_status_o(serial_status_o), .index_o(index_o));
  bcrl_app_model u_app (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
    .rd_o(rd_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (mem_wr_o.valid === 1'b1) got.push_back(mem_wr_o);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_wr(input bcrl_wr_t e, input bcrl_wr_t g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected word expected %h seen %h", e, g);
    end
  endtask
  function automatic bcrl_clk_t exp_clk(input bcrl_mode_t m);
    logic pll;
    pll = !(m inside {BCRL_BOOT_NONE, BCRL_BOOT_EXT});
    return {pll, pll, 1'b1, 1'b0, `BCRL_DIV_ONE};
  endfunction
  task automatic do_reset(input bcrl_mode_t m);
    @(posedge clk_i);
    boot_mode_i <= m;
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic wait_done(output logic [31:0] d);
    for (int k = 0; k < 300; k++) begin
      u_app.rd(`BCRL_OFF_STATUS, d);
      if (d[`BCRL_ST_BUSY] === 1'b0) break;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    num_errors++;
    finish_test();
  end
  initial begin
    logic [31:0] d;
    logic [15:0] n;
    logic [15:0] s;
    logic [7:0]  p;
    static logic [2:0]  bad_e [4] = '{3'h0, 3'h7, 3'h1, 3'h4};
    static logic [15:0] bad_n [4] = '{16'h1, 16'h1, 16'h4000, 16'h7d01};
    srst_i = 1'b1;
    boot_mode_i = BCRL_BOOT_NONE;
    void'($urandom(32'hb9c0));
    for (int m = 0; m < 7; m++) begin
      do_reset(bcrl_mode_t'(m));
      chk("clock", 32'(exp_clk(bcrl_mode_t'(m))), 32'(clk_ctrl_o));
      chk("caller pll", 32'(u_app.must_start_pll(3'(m))), 32'(!clk_ctrl_o.pll_run));
      u_app.rd(`BCRL_OFF_DPSEL, d);
      chk("page", 32'(`BCRL_PAGE_INIT), d);
    end
    for (int e = 1; e <= 6; e++) begin
      n = (e == 1) ? 16'd64 : 16'($urandom_range(8, 1));
      p = (e % 2) ? 8'($urandom_range(63)) : 8'($urandom_range(255, 64));
      if (e == 2) p = `BCRL_PAGE_DATA_MAX;
      if (e == 4) p = `BCRL_PAGE_INIT;
      s = u_app.src_for(3'(e), 16'($urandom));
      for (int i = 0; i < n; i++) u_app.words[i] = $urandom;
      got.delete();
      u_app.reboot(3'(e), n, s, p);
      wait_done(d);
      chk("status", 32'h2, {29'h0, d[2:0]});
      chk("count", 32'(n), 32'(got.size()));
      foreach (got[i]) chk_wr({1'b1, p <= `BCRL_PAGE_DATA_MAX, p, 16'(i), u_app.words[i]}, got[i]);
      u_app.rd(`BCRL_OFF_DPSEL, d);
      chk("page", 32'(`BCRL_PAGE_RESET), d);
      u_app.rd(`BCRL_OFF_STACK, d);
      chk("stack", 32'h0, d);
      case (e)
        4: begin
          chk("index", 32'(s), 32'(index_o));
          chk("dest", 32'h8000, 32'(u_app.dest_of(p, got[0].addr)));
        end
        5: chk("host", 32'(s), 32'(host_status_o));
        6: chk("serial", 32'(`BCRL_SST_FIXED), 32'(serial_status_o));
        default: ;
      endcase
    end
    for (int k = 0; k < 4; k++) begin
      got.delete();
      u_app.reboot(bad_e[k], bad_n[k], 16'h0, 8'h80);
      wait_done(d);
      chk("error", 32'h1, 32'(d[`BCRL_ST_ERR]));
      chk("count", 32'h0, 32'(got.size()));
    end
    for (int i = 0; i < 4; i++) u_app.words[i] = $urandom;
    got.delete();
    u_app.reboot(3'h3, 16'h4, 16'h0, 8'h10);
    wait_done(d);
    chk("status", 32'h2, {29'h0, d[2:0]});
    chk("count", 32'h4, 32'(got.size()));
    foreach (got[i]) chk_wr({1'b1, 1'b1, 8'h10, 16'(i), u_app.words[i]}, got[i]);
    finish_test();
  end
endmodule // boot_clock_and_reboot_loader_tb_top
bind bcrl_top bcrl_monitor u_mon (.clk_i(clk_i), .srst_i(srst_i), .boot_mode_i(boot_mode_i),
  .clk_ctrl_o(clk_ctrl_o), .mem_wr_o(mem_wr_o), .serial_status_o(serial_status_o));
